// file: include/ccm_pkg.sv
// constants and state type for the cache configuration register bank
package ccm_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_POWERON = 10'h02a;
  localparam logic [9:0] IDX_TEST = 10'h033;
  localparam logic [9:0] IDX_UPDT = 10'h079;
  localparam logic [9:0] IDX_CHUNK0 = 10'h088;
  localparam logic [9:0] IDX_CHUNK1 = 10'h089;
  localparam logic [9:0] IDX_CHUNK2 = 10'h08a;
  localparam logic [9:0] IDX_CHUNK3 = 10'h08b;
  localparam logic [9:0] IDX_PERF0 = 10'h0c1;
  localparam logic [9:0] IDX_PERF1 = 10'h0c2;
  localparam logic [9:0] IDX_RANGECAP = 10'h0fe;
  localparam logic [9:0] IDX_ADDR = 10'h116;
  localparam logic [9:0] IDX_ECC = 10'h118;
  localparam logic [9:0] IDX_TRIG = 10'h11a;
  localparam logic [9:0] IDX_BUSY = 10'h11b;
  localparam logic [9:0] IDX_ACCESS_CTL = 10'h200;
  localparam int NUM_CHUNKS = 4;
  // power-on configuration fields
  localparam int POW_FREQ_LSB = 18;
  localparam int POW_ARB_LSB = 20;
  localparam int POW_RATIO_LSB = 22;
  localparam int POW_LOWPWR_BIT = 26;
  localparam int POW_RATIO_HI_BIT = 27;
  localparam logic [1:0] FREQ_66 = 2'h0;
  localparam logic [1:0] FREQ_100 = 2'h2;
  localparam logic [1:0] FREQ_133 = 2'h1;
  localparam logic [1:0] FREQ_RSVD = 2'h3;
  // test control fields
  localparam int TEST_STREAM_BIT = 30;
  localparam int TEST_SPLIT_BIT = 31;
  // cache address fields
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 35;
  localparam int ECC_W = 8;
  // access control fields
  localparam int ACTL_HIGH_BIT = 0;
  localparam int ACTL_SIG_BIT = 1;
  localparam logic [63:0] RANGE_CAP_VALUE = 64'h0;
  localparam logic [31:0] TRIG_START_DATA = 32'h0;

  typedef struct packed {
    logic [NUM_CHUNKS-1:0][63:0] chunk;
    logic [ADDR_MSB-ADDR_LSB:0] addr;
    logic [ECC_W-1:0] ecc;
    logic stream_dis;
    logic split_nolock;
    logic low_power;
    logic [1:0] freq;
    logic [1:0] arb_id;
    logic [3:0] ratio;
    logic ratio_hi;
    logic strap_done;
    logic [63:0] perf0;
    logic [63:0] perf1;
    logic high_half;
    logic sig_mode;
    logic busy;
    logic start;
    logic updt;
    logic bus_lock;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccm_state_t;
endpackage

// file: hw/ccm_bank.sv
// model-specific register bank for cache configuration accesses over apb
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

// Operation
// - bus frequency code reads 00/10/01 for 66/100/133 MHz, 11 reserved.
// - power-on bit 26 is a read/write low-power mode enable.
// - test control bit 31 stops bus lock for split locked accesses.
// - four 64-bit chunk data registers stage cache write and read data.
// - register 8B is update signature or fourth chunk, by usage mode.
// - cache address holds bits 35:3; bits 2:0 reserved, written zero.
// - ecc register low byte goes to cache and is captured back.
// - writing zero to trigger starts a cache configuration command.
// - busy bit 0 is one while a command runs, cleared at completion.
module ccm_bank
  import ccm_pkg::*;
(
  // apb
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // configuration straps, sampled once after reset
  input logic [1:0] bus_freq_strap,
  input logic [1:0] arb_id_strap,
  input logic [3:0] ratio_strap,
  input logic ratio_hi_strap,
  // bus lock, streaming buffer, low power enable and update trigger
  input logic locked_access,
  input logic split_access,
  output logic bus_lock,
  output logic stream_buf_disable,
  output logic low_power_en,
  output logic update_trigger_pulse,
  // secondary cache configuration access
  output logic cache_start,
  output logic [35:0] cache_addr,
  output logic [255:0] cache_wdata,
  output logic [7:0] cache_wecc,
  input logic cache_done,
  input logic cache_capture,
  input logic [255:0] cache_rdata,
  input logic [7:0] cache_recc
);

  ccm_state_t s;
  ccm_state_t n;
  logic [9:0] idx;
  logic setup;
  logic wr_acc;
  logic rd_hit;
  logic [63:0] rd64;
  logic [63:0] wr64;

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && s.pready;

  // read mux over the whole bank
  always_comb
  begin
    rd64 = 64'h0;
    rd_hit = (paddr[1:0] == 2'h0);
    if (idx == IDX_POWERON)
    begin
      rd64[POW_FREQ_LSB +: 2] = s.freq;
      rd64[POW_ARB_LSB +: 2] = s.arb_id;
      rd64[POW_RATIO_LSB +: 4] = s.ratio;
      rd64[POW_LOWPWR_BIT] = s.low_power;
      rd64[POW_RATIO_HI_BIT] = s.ratio_hi;
    end
    else if (idx == IDX_TEST)
    begin
      rd64[TEST_STREAM_BIT] = s.stream_dis;
      rd64[TEST_SPLIT_BIT] = s.split_nolock;
    end
    else if (idx == IDX_UPDT)
      rd64 = 64'h0;
    else if (idx >= IDX_CHUNK0 && idx <= IDX_CHUNK3)
      rd64 = s.chunk[idx[1:0]];
    else if (idx == IDX_PERF0)
      rd64 = s.perf0;
    else if (idx == IDX_PERF1)
      rd64 = s.perf1;
    else if (idx == IDX_RANGECAP)
      rd64 = RANGE_CAP_VALUE;
    else if (idx == IDX_ADDR)
      rd64[ADDR_MSB:ADDR_LSB] = s.addr;
    else if (idx == IDX_ECC)
      rd64[ECC_W-1:0] = s.ecc;
    else if (idx == IDX_TRIG)
      rd64 = 64'h0;
    else if (idx == IDX_BUSY)
      rd64[0] = s.busy;
    else if (idx == IDX_ACCESS_CTL)
    begin
      rd64[ACTL_HIGH_BIT] = s.high_half;
      rd64[ACTL_SIG_BIT] = s.sig_mode;
    end
    else
      rd_hit = 1'b0;
  end

  // writes land in the half of the 64-bit register picked by high_half
  assign wr64 = s.high_half ? {pwdata, rd64[31:0]} : {rd64[63:32], pwdata};

  always_comb
  begin
    n = s;
    n.start = 1'b0;
    n.updt = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // straps are caught on the first clock after reset release
    if (!s.strap_done)
    begin
      n.freq = bus_freq_strap;
      n.arb_id = arb_id_strap;
      n.ratio = ratio_strap;
      n.ratio_hi = ratio_hi_strap;
      n.strap_done = 1'b1;
    end
    n.bus_lock = locked_access && !(split_access && s.split_nolock);
    if (setup)
    begin
      n.pready = 1'b1;
      n.pslverr = !rd_hit;
      n.prdata = s.high_half ? rd64[63:32] : rd64[31:0];
    end
    // completion: the engine's answer lands in the staging registers
    if (s.busy && cache_done)
    begin
      n.busy = 1'b0;
      if (cache_capture)
      begin
        for (int i = 0; i < NUM_CHUNKS; i++)
        begin
          // signature mode keeps register 8B out of the capture
          if (!(s.sig_mode && i == NUM_CHUNKS - 1))
            n.chunk[i] = cache_rdata[i*64 +: 64];
        end
        n.ecc = cache_recc;
      end
    end
    if (wr_acc && !s.pslverr)
    begin
      if (idx == IDX_POWERON)
        n.low_power = wr64[POW_LOWPWR_BIT];
      else if (idx == IDX_TEST)
      begin
        n.stream_dis = wr64[TEST_STREAM_BIT];
        n.split_nolock = wr64[TEST_SPLIT_BIT];
      end
      else if (idx == IDX_UPDT)
        n.updt = 1'b1;
      else if (idx >= IDX_CHUNK0 && idx <= IDX_CHUNK3)
        n.chunk[idx[1:0]] = wr64;
      else if (idx == IDX_PERF0)
        n.perf0 = wr64;
      else if (idx == IDX_PERF1)
        n.perf1 = wr64;
      else if (idx == IDX_ADDR)
        n.addr = wr64[ADDR_MSB:ADDR_LSB];
      else if (idx == IDX_ECC)
        n.ecc = wr64[ECC_W-1:0];
      else if (idx == IDX_TRIG)
      begin
        // nonzero data or a write while busy is dropped silently
        if (pwdata == TRIG_START_DATA && !s.busy)
        begin
          n.start = 1'b1;
          n.busy = 1'b1;
        end
      end
      else if (idx == IDX_ACCESS_CTL)
      begin
        n.high_half = pwdata[ACTL_HIGH_BIT];
        n.sig_mode = pwdata[ACTL_SIG_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign prdata = s.prdata;
  assign bus_lock = s.bus_lock;
  assign stream_buf_disable = s.stream_dis;
  assign low_power_en = s.low_power;
  assign update_trigger_pulse = s.updt;
  assign cache_start = s.start;
  assign cache_addr = {s.addr, 3'h0};
  assign cache_wdata = s.chunk;
  assign cache_wecc = s.ecc;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence poweron_read;
    setup && idx == IDX_POWERON && !s.high_half && s.strap_done;
  endsequence

  sequence trig_write;
    wr_acc && !s.pslverr && idx == IDX_TRIG && pwdata == TRIG_START_DATA
      && !s.busy;
  endsequence

  sequence cmd_running;
    cache_start && s.busy ##1 !cache_start;
  endsequence

  freq_report_a: assert property (poweron_read |=>
    prdata[POW_FREQ_LSB +: 2] == s.freq)
    else $error("bus frequency code misreported");

  low_power_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_POWERON |=>
    low_power_en == $past(wr64[POW_LOWPWR_BIT]))
    else $error("low power enable not written");

  lock_gate_a: assert property (
    s.split_nolock && split_access |=> !bus_lock)
    else $error("bus lock asserted for split access");

  chunk_write_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_CHUNK1 && !s.high_half
    && !(s.busy && cache_done) |=> cache_wdata[95:64] == $past(pwdata))
    else $error("chunk data write lost");

  sig_mode_a: assert property (
    s.sig_mode && s.busy && cache_done && cache_capture
    && !(wr_acc && idx == IDX_CHUNK3) |=> $stable(s.chunk[3]))
    else $error("signature overwritten by capture");

  addr_rsvd_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_ADDR && !s.high_half |=>
    cache_addr[31:0] == {$past(pwdata[31:3]), 3'h0})
    else $error("address low word or reserved bits wrong");

  ecc_capture_a: assert property (
    s.busy && cache_done && cache_capture |=> cache_wecc == $past(cache_recc))
    else $error("ecc not captured");

  stream_dis_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_TEST |=>
    stream_buf_disable == $past(pwdata[TEST_STREAM_BIT]) || s.high_half)
    else $error("streaming disable not written");

  trig_start_a: assert property (trig_write |=> cmd_running)
    else $error("trigger did not start command");

  busy_clear_a: assert property (
    s.busy && cache_done |=> !s.busy ##1 !cache_start)
    else $error("busy not cleared at completion");

  sequence ack_pulse;
    pready ##1 !pready;
  endsequence

  ready_pulse_a: assert property (setup |=> ack_pulse)
    else $error("access not acknowledged for exactly one cycle");

  unmapped_err_a: assert property (
    setup && idx > IDX_ACCESS_CTL |=> pslverr)
    else $error("unmapped access not flagged");

  updt_pulse_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_UPDT |=>
    update_trigger_pulse ##1 !update_trigger_pulse)
    else $error("update trigger pulse wrong");

  trig_ignore_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_TRIG && pwdata != TRIG_START_DATA
    |=> !cache_start)
    else $error("nonzero trigger write started a command");

  start_busy_a: assert property (cache_start |-> s.busy)
    else $error("command started without busy");

  busy_read_a: assert property (
    setup && idx == IDX_BUSY && !s.high_half |=> prdata[0] == $past(s.busy))
    else $error("busy bit misreported");

  ecc_write_a: assert property (
    wr_acc && !s.pslverr && idx == IDX_ECC && !s.high_half
    && !(s.busy && cache_done && cache_capture)
    |=> cache_wecc == $past(pwdata[ECC_W-1:0]))
    else $error("ecc write lost");

  lock_pass_a: assert property (
    locked_access && !split_access |=> bus_lock)
    else $error("bus lock missing for plain locked access");

endmodule

// file: sim/ccm_bank_bench.sv
// self-checking bench for the cache configuration register bank
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("ERROR %0t: got %h want %h", $time, a, b); \
    end \
  end

module ccm_bank_bench
  import ccm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] bus_freq_strap, arb_id_strap;
  logic [3:0] ratio_strap;
  logic ratio_hi_strap, locked_access, split_access, bus_lock;
  logic stream_buf_disable, low_power_en, update_trigger_pulse, cache_start;
  logic [35:0] cache_addr;
  logic [255:0] cache_wdata, cache_rdata;
  logic [7:0] cache_wecc, cache_recc;
  logic cache_done, cache_capture;
  logic [63:0] q;
  int err_count, samples_checked;

  ccm_bank dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .bus_freq_strap(bus_freq_strap),
    .arb_id_strap(arb_id_strap), .ratio_strap(ratio_strap),
    .ratio_hi_strap(ratio_hi_strap), .locked_access(locked_access),
    .split_access(split_access), .bus_lock(bus_lock),
    .stream_buf_disable(stream_buf_disable), .low_power_en(low_power_en),
    .update_trigger_pulse(update_trigger_pulse), .cache_start(cache_start),
    .cache_addr(cache_addr), .cache_wdata(cache_wdata),
    .cache_wecc(cache_wecc), .cache_done(cache_done),
    .cache_capture(cache_capture), .cache_rdata(cache_rdata),
    .cache_recc(cache_recc)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // one apb transfer; result left in rd and er
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // 64-bit access as two halves picked through the access control word
  task automatic acc64(input logic w, input logic [9:0] idx,
                       input logic [63:0] v);
    apb(1'b1, IDX_ACCESS_CTL, {30'h0, sig, 1'b0});
    apb(w, idx, v[31:0]);
    q[31:0] = rd;
    apb(1'b1, IDX_ACCESS_CTL, {30'h0, sig, 1'b1});
    apb(w, idx, v[63:32]);
    q[63:32] = rd;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sig, presetn} = '0;
    {locked_access, split_access, cache_done, cache_capture} = '0;
    {cache_rdata, cache_recc, ratio_hi_strap} = '0;
    {bus_freq_strap, arb_id_strap, ratio_strap} = '0;
    err_count = 0;
    samples_checked = 0;
    // straps are taken once, so each frequency code needs its own reset
    for (int i = 0; i < 4; i++)
    begin
      bus_freq_strap <= 2'(i);
      arb_id_strap <= 2'(3 - i);
      ratio_strap <= 4'(9 + i);
      ratio_hi_strap <= i[0];
      do_reset();
      apb(1'b0, IDX_POWERON, 32'h0);
      `CHK(rd[19:18], 2'(i));
      `CHK(rd[27:20], {i[0], 1'b0, 4'(9 + i), 2'(3 - i)});
    end
    apb(1'b1, IDX_POWERON, 32'h0400_0000);
    apb(1'b0, IDX_POWERON, 32'h0);
    `CHK({rd[26], low_power_en}, 2'b11);
    apb(1'b1, IDX_POWERON, 32'h0);
    apb(1'b0, IDX_POWERON, 32'h0);
    `CHK({rd[26], low_power_en}, 2'b00);
    locked_access <= 1'b1;
    split_access <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, IDX_TEST, {2'(i), 30'h0});
      repeat (2) @(posedge pclk);
      #1;
      `CHK(stream_buf_disable, i[0]);
      `CHK(bus_lock, ~i[1]);
    end
    @(posedge pclk);
    split_access <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK(bus_lock, 1'b1);
    apb(1'b1, IDX_UPDT, 32'h0);
    #1;
    `CHK(update_trigger_pulse, 1'b1);
    apb(1'b1, IDX_RANGECAP, 32'hffff_ffff);
    apb(1'b0, IDX_RANGECAP, 32'h0);
    `CHK(rd, 32'h0);
    apb(1'b0, 10'h3ff, 32'h0);
    `CHK(er, 1'b1);
    acc64(1'b1, IDX_ADDR, 64'h0000_0009_8765_4320);
    acc64(1'b0, IDX_ADDR, 64'h0);
    `CHK(q, 64'h0000_0009_8765_4320);
    `CHK(cache_addr, 36'h9_8765_4320);
    // the ecc byte lives in the low half
    apb(1'b1, IDX_ACCESS_CTL, 32'h0);
    apb(1'b1, IDX_ECC, 32'h0000_00a5);
    #1;
    `CHK(cache_wecc, 8'ha5);
    for (int i = 0; i < NUM_CHUNKS; i++)
      acc64(1'b1, IDX_CHUNK0 + 10'(i), {8{8'(8'h50 + i)}});
    #1;
    for (int i = 0; i < NUM_CHUNKS; i++)
      `CHK(cache_wdata[64*i +: 64], {8{8'(8'h50 + i)}});
    // signature mode first, so chunk 3 must survive the capture
    for (int s = 1; s >= 0; s--)
    begin
      sig = s[0];
      acc64(1'b1, IDX_CHUNK3, 64'h5a5a_5a5a_5a5a_5a5a);
      // busy and ecc are read from the low half
      apb(1'b1, IDX_ACCESS_CTL, {30'h0, sig, 1'b0});
      apb(1'b1, IDX_TRIG, 32'h1);
      #1;
      `CHK(cache_start, 1'b0);
      apb(1'b1, IDX_TRIG, TRIG_START_DATA);
      #1;
      `CHK(cache_start, 1'b1);
      apb(1'b0, IDX_BUSY, 32'h0);
      `CHK(rd[0], 1'b1);
      @(posedge pclk);
      cache_done <= 1'b1;
      cache_capture <= 1'b1;
      cache_recc <= 8'(8'h3c + s);
      for (int i = 0; i < NUM_CHUNKS; i++)
        cache_rdata[64*i +: 64] <= {8{8'(8'ha0 + i)}};
      @(posedge pclk);
      cache_done <= 1'b0;
      cache_capture <= 1'b0;
      apb(1'b0, IDX_BUSY, 32'h0);
      `CHK(rd[0], 1'b0);
      apb(1'b0, IDX_ECC, 32'h0);
      `CHK(rd[7:0], 8'(8'h3c + s));
      acc64(1'b0, IDX_CHUNK0, 64'h0);
      `CHK(q, {8{8'ha0}});
      acc64(1'b0, IDX_CHUNK3, 64'h0);
      `CHK(q, s ? 64'h5a5a_5a5a_5a5a_5a5a : {8{8'ha3}});
    end
    report_and_stop();
  end

  initial
  begin
    #(25 * 20000);
    err_count++;
    report_and_stop();
  end
endmodule
